/* File: hdl/fpec_pkg.sv */
// ==========================================
// Shared constants and types
// ==========================================
package fpec_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_PAGE = 8'h08;
  localparam logic [7:0] OFS_LOW = 8'h0C;
  localparam logic [7:0] OFS_HIGH = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // Control register field positions
  localparam int BIT_START = 15;
  localparam int BIT_PERMIT = 14;
  localparam int BIT_FAULT = 13;
  localparam int BIT_ERASE = 6;
  // Operation codes
  localparam logic [3:0] OPC_BULK = 4'hF;
  localparam logic [3:0] OPC_GEN = 4'hD;
  localparam logic [3:0] OPC_SEC = 4'hC;
  localparam logic [3:0] OPC_WORD = 4'h3;
  localparam logic [3:0] OPC_PAGE = 4'h2;
  localparam logic [3:0] OPC_ROW = 4'h1;
  localparam logic [3:0] OPC_CFG = 4'h0;
  // Unlock key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Alignment masks: page is 512 words, row is 64 words
  localparam logic [23:0] PAGE_MASK = 24'hFF_FC00;
  localparam logic [23:0] ROW_MASK = 24'hFF_FF80;
  // Self-timed operation length
  localparam int OP_TIME_NS = 1586000;
  localparam int CLK_NS = 5;
  localparam int OP_CYCLES_DEF = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
  // Bus responses and reset values
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  // Operation handed to the flash array
  typedef enum logic [3:0] {
    FK_NONE = 4'h0, FK_ROW = 4'h1, FK_WORD = 4'h2, FK_PAGE = 4'h3, FK_BULK = 4'h4,
    FK_GEN = 4'h5, FK_SEC = 4'h6, FK_CFG_PROG = 4'h7, FK_CFG_ERASE = 4'h8
  } fpec_kind_type;
  typedef struct packed {
    fpec_kind_type kind;
    logic [23:0] addr;
  } fpec_cmd_type;
  // Unlock and operation state machines
  typedef enum logic [2:0] {LK_SHUT = 3'b001, LK_HALF = 3'b010, LK_OPEN = 3'b100} fpec_lock_type;
  typedef enum logic [1:0] {OP_IDLE = 2'b01, OP_RUN = 2'b10} fpec_op_type;
endpackage

/* File: hdl/fpec_top.sv */
// Notes on behaviour
// - Start bit launches operation, hardware clears it
// - Software can only set start bit
// - Modify permit gates every operation
// - Fault flag on bad sequence or abort
// - Erase select picks erase or program variant
// - Codes 1111/1101/1100 erase only with erase
// - 0011 word and 0001 row program with erase clear, 0010 page erase
// - Code 0000 programs or erases config byte
// - Reserved codes start no flash activity
// - Control bits clear only on power-on reset
// - Unimplemented control bits read zero
// - Low table store latches erase target address
// - Unlock 0x55 then 0xAA before start
// - CPU stalled for the whole operation
// - Row program writes 64-word holding buffer
// - Address is page pointer plus effective address
// - Low store bits 15:0, high 23:16
// - Pages and rows aligned to boundaries
`timescale 1ns/1ps
module fpec_top import fpec_pkg::*; #(
  parameter int OP_CYCLES = OP_CYCLES_DEF
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic flash_abort_in,
  input wire logic [5:0] flash_buf_index_in,
  output logic [23:0] flash_buf_word_out,
  output logic flash_active_out,
  output fpec_cmd_type flash_cmd_out,
  output logic cpu_stall_out
);
  localparam logic [18:0] LAST_CYCLE = 19'(OP_CYCLES - 1);

  // ==========================================
  // State
  // ==========================================
  // Bus channel state
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  // Control register fields
  logic start_q, start_d, permit_q, permit_d, fault_q, fault_d, erase_q, erase_d;
  logic [3:0] opc_q, opc_d;
  // Table pointer, erase target, sequencer
  logic [7:0] page_q, page_d;
  logic [23:0] target_q, target_d;
  fpec_lock_type lock_q, lock_d;
  fpec_op_type op_q, op_d;
  logic [18:0] cnt_q, cnt_d;
  fpec_cmd_type cmd_q, cmd_d;
  // Holding buffer and its write strobes
  logic [23:0] buf_q [64];
  logic [23:0] buf_word_q;
  logic buf_we_lo0, buf_we_lo1, buf_we_hi;
  logic [5:0] buf_idx;
  // Scratch values
  logic do_wr;
  logic [15:0] ea;
  logic new_permit, new_erase;
  logic [3:0] new_opc;
  fpec_kind_type kind;

  // ==========================================
  // Operation decode
  // ==========================================
  // Maps code and erase select to an operation, none on mismatch
  function automatic fpec_kind_type decode(input logic [3:0] opc, input logic ers);
    fpec_kind_type k;
    k = FK_NONE;
    unique case (opc)
      OPC_BULK: k = ers ? FK_BULK : FK_NONE;
      OPC_GEN: k = ers ? FK_GEN : FK_NONE;
      OPC_SEC: k = ers ? FK_SEC : FK_NONE;
      OPC_WORD: k = ers ? FK_NONE : FK_WORD;
      OPC_PAGE: k = ers ? FK_PAGE : FK_NONE;
      OPC_ROW: k = ers ? FK_NONE : FK_ROW;
      OPC_CFG: k = ers ? FK_CFG_ERASE : FK_CFG_PROG;
      default: k = FK_NONE; // Reserved codes
    endcase
    return k;
  endfunction

  // ==========================================
  // Next-state logic
  // ==========================================
  // Bus handshakes, register effects, unlock and timing
  always_comb begin
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    rdata_d = rdata_q;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    start_d = start_q;
    permit_d = permit_q;
    fault_d = fault_q;
    erase_d = erase_q;
    opc_d = opc_q;
    page_d = page_q;
    target_d = target_q;
    lock_d = lock_q;
    op_d = op_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    buf_we_lo0 = 1'b0;
    buf_we_lo1 = 1'b0;
    buf_we_hi = 1'b0;
    ea = wdata_q[31:16];
    buf_idx = ea[6:1];
    new_permit = permit_q;
    new_erase = erase_q;
    new_opc = opc_q;
    kind = FK_NONE;
    // Capture address and data in either order
    if (s_axi_awvalid_in && awready_q) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr_in;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid_in && wready_q) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata_in;
      wstrb_d = s_axi_wstrb_in;
      wready_d = 1'b0;
    end
    do_wr = aw_hold_q && w_hold_q && !bvalid_q;
    // Self-timed operation in progress
    if (op_q == OP_RUN) begin
      cnt_d = cnt_q + 19'd1;
      if (flash_abort_in) begin
        fault_d = 1'b1; // Abnormal end
        start_d = 1'b0;
        op_d = OP_IDLE;
        cmd_d.kind = FK_NONE;
      end else if (cnt_q == LAST_CYCLE) begin
        start_d = 1'b0; // Hardware completion clears start
        op_d = OP_IDLE;
        cmd_d.kind = FK_NONE;
      end
    end
    // Perform a held write
    if (do_wr) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (awaddr_q != OFS_KEY) begin
        lock_d = LK_SHUT; // Any other write breaks the key sequence
      end
      unique case (awaddr_q)
        OFS_KEY: begin
          if (wdata_q[7:0] == KEY_FIRST) begin
            lock_d = LK_HALF;
          end else if (wdata_q[7:0] == KEY_SECOND && lock_q == LK_HALF) begin
            lock_d = LK_OPEN;
          end else begin
            lock_d = LK_SHUT;
          end
        end
        OFS_CTRL: begin
          // Ignored while the operation runs
          if (op_q == OP_IDLE) begin
            if (wstrb_q[0]) begin
              new_erase = wdata_q[BIT_ERASE];
              new_opc = wdata_q[3:0];
            end
            if (wstrb_q[1]) begin
              new_permit = wdata_q[BIT_PERMIT];
              fault_d = wdata_q[BIT_FAULT];
            end
            erase_d = new_erase;
            opc_d = new_opc;
            permit_d = new_permit;
            kind = decode(new_opc, new_erase);
            // Writing zero to start has no effect
            if (wstrb_q[1] && wdata_q[BIT_START]) begin
              if (lock_q != LK_OPEN || !new_permit) begin
                fault_d = 1'b1; // No flash change
              end else if (kind != FK_NONE) begin
                start_d = 1'b1;
                fault_d = 1'b0;
                op_d = OP_RUN;
                cnt_d = '0;
                cmd_d.kind = kind;
                cmd_d.addr = target_q;
                if (kind == FK_PAGE) begin
                  cmd_d.addr = target_q & PAGE_MASK;
                end else if (kind == FK_ROW) begin
                  cmd_d.addr = target_q & ROW_MASK;
                end
              end else begin
                fault_d = 1'b0; // Unlocked but no operation selected
              end
            end
          end
        end
        OFS_PAGE: begin
          if (wstrb_q[0]) begin
            page_d = wdata_q[7:0];
          end
        end
        OFS_LOW: begin
          buf_we_lo0 = wstrb_q[0];
          buf_we_lo1 = wstrb_q[1];
          target_d = {page_q, ea};
        end
        OFS_HIGH: begin
          buf_we_hi = wstrb_q[0];
        end
        OFS_STAT: begin
        end
        default: bresp_d = RESP_SLVERR;
      endcase
      if (awaddr_q == OFS_CTRL && wstrb_q[1] && wdata_q[BIT_START]) begin
        lock_d = LK_SHUT; // Unlock used up by the attempt
      end
    end
    if (bvalid_q && s_axi_bready_in) begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    // Read channel
    if (s_axi_arvalid_in && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = ZERO32;
      unique case (s_axi_araddr_in)
        OFS_CTRL: begin
          rdata_d[BIT_START] = start_q; // Other bits stay zero
          rdata_d[BIT_PERMIT] = permit_q;
          rdata_d[BIT_FAULT] = fault_q;
          rdata_d[BIT_ERASE] = erase_q;
          rdata_d[3:0] = opc_q;
        end
        OFS_PAGE: rdata_d[7:0] = page_q;
        OFS_STAT: rdata_d = {6'h00, lock_q == LK_OPEN, op_q == OP_RUN, target_q};
        OFS_KEY, OFS_LOW, OFS_HIGH: rdata_d = ZERO32;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready_in) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    // Other resets restart bus and unlock only
    if (sys_rst_in) begin
      awready_d = 1'b1;
      wready_d = 1'b1;
      arready_d = 1'b1;
      bvalid_d = 1'b0;
      rvalid_d = 1'b0;
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      lock_d = LK_SHUT;
    end
  end

  // ==========================================
  // Registers
  // ==========================================
  // Power-on reset clears all but the holding buffer, control bits included
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= ZERO32;
      wstrb_q <= '0;
      rdata_q <= ZERO32;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      start_q <= 1'b0;
      permit_q <= 1'b0;
      fault_q <= 1'b0;
      erase_q <= 1'b0;
      opc_q <= '0;
      page_q <= '0;
      target_q <= '0;
      lock_q <= LK_SHUT;
      op_q <= OP_IDLE;
      cnt_q <= '0;
      cmd_q <= '{kind: FK_NONE, addr: '0};
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      rdata_q <= rdata_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      start_q <= start_d;
      permit_q <= permit_d;
      fault_q <= fault_d;
      erase_q <= erase_d;
      opc_q <= opc_d;
      page_q <= page_d;
      target_q <= target_d;
      lock_q <= lock_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
    end
  end

  // Holding buffer words, 64 entries, not reset
  always_ff @(posedge clock_in) begin
    if (buf_we_lo0) begin
      buf_q[buf_idx][7:0] <= wdata_q[7:0];
    end
    if (buf_we_lo1) begin
      buf_q[buf_idx][15:8] <= wdata_q[15:8];
    end
    if (buf_we_hi) begin
      buf_q[buf_idx][23:16] <= wdata_q[7:0];
    end
    buf_word_q <= buf_q[flash_buf_index_in];
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign flash_buf_word_out = buf_word_q;
  assign flash_active_out = start_q;
  assign flash_cmd_out = cmd_q;
  assign cpu_stall_out = start_q; // Stall follows start bit
endmodule

/* File: test/fpec_top_chk.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker for the flash control block
module fpec_top_chk import fpec_pkg::*; #(
  parameter int OP_CYCLES = 20
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic flash_abort_in,
  input wire logic flash_active_out,
  input wire fpec_cmd_type flash_cmd_out,
  input wire logic cpu_stall_out
);
  // Cycles the running operation has lasted, and the last read address
  logic [31:0] cnt_q, cnt_d;
  logic [7:0] ra_q, ra_d;
  always_comb begin
    cnt_d = flash_active_out ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
    ra_d = (s_axi_arvalid_in && s_axi_arready_out) ? s_axi_araddr_in : ra_q;
  end
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= 32'h0000_0000;
      ra_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
      ra_q <= ra_d;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  chk_stall_tracks: assert property (cpu_stall_out == flash_active_out)
    else $error("stall differs from active");
  chk_op_bound: assert property (flash_active_out |-> cnt_q < OP_CYCLES)
    else $error("operation runs too long");
  chk_op_length: assert property ($fell(flash_active_out) && !$past(flash_abort_in)
    && !$past(flash_abort_in, 2) |-> $past(cnt_q) == OP_CYCLES - 1) else $error("operation ended early");
  chk_cmd_launch: assert property ($rose(flash_active_out) |-> flash_cmd_out.kind != FK_NONE)
    else $error("launch without command");
  chk_cmd_idle: assert property (!flash_active_out |-> flash_cmd_out.kind == FK_NONE)
    else $error("command while idle");
  chk_cmd_stable: assert property (flash_active_out && $past(flash_active_out) |-> $stable(flash_cmd_out))
    else $error("command moved while running");
  chk_page_align: assert property (flash_active_out && flash_cmd_out.kind == FK_PAGE
    |-> flash_cmd_out.addr[9:0] == 10'h000) else $error("page address not aligned");
  chk_row_align: assert property (flash_active_out && flash_cmd_out.kind == FK_ROW
    |-> flash_cmd_out.addr[6:0] == 7'h00) else $error("row address not aligned");
  chk_ctrl_spare: assert property (s_axi_rvalid_out && ra_q == OFS_CTRL
    |-> s_axi_rdata_out[12:7] == 6'h00 && s_axi_rdata_out[5:4] == 2'h0) else $error("spare bits not zero");
  chk_key_read: assert property (s_axi_rvalid_out && ra_q == OFS_KEY |-> s_axi_rdata_out == ZERO32)
    else $error("key port reads nonzero");
endmodule
bind fpec_top fpec_top_chk #(.OP_CYCLES(OP_CYCLES)) u_fpec_top_chk (.clock_in(clock_in), .arst_n_in(arst_n_in),
  .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out), .flash_abort_in(flash_abort_in),
  .flash_active_out(flash_active_out), .flash_cmd_out(flash_cmd_out), .cpu_stall_out(cpu_stall_out));

/* File: test/tb_fpec_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
// ==========================================
// Bench for the flash control block
module tb_fpec_top import fpec_pkg::*;;
  localparam int OPC = 20;
  logic clock_in = 1'b0, arst_n_in = 1'b0, sys_rst_in = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, abort = 1'b0, act_seen = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [5:0] bidx = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, cpu_stall, active;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] bword, tgt;
  logic [23:0] bw[64];
  logic [34:0] er;
  logic [1:0] eb;
  fpec_cmd_type ec;
  fpec_cmd_type cmd;
  logic [34:0] rq[$];
  logic [1:0] bq[$];
  fpec_cmd_type cq[$];
  int n_mismatch = 0, cmp_count = 0, n = 0;
  int seed = 32'h981a_bf6b;
  fpec_top #(.OP_CYCLES(OPC)) u_fpec_top (.clock_in(clock_in), .arst_n_in(arst_n_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(1'b1), .flash_abort_in(abort), .flash_buf_index_in(bidx), .flash_buf_word_out(bword),
    .flash_active_out(active), .flash_cmd_out(cmd), .cpu_stall_out(cpu_stall));
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end
  // Watcher: each answer takes the oldest note off its queue
  always @(posedge clock_in) begin
    act_seen <= active;
    if (rvalid) begin
      er = rq.size() ? rq.pop_front() : 35'h3_0000_0000;
      `CHK("rresp", er[33:32], rresp)
      if (er[34]) `CHK("rdata", er[31:0], rdata)
    end
    if (bvalid) begin
      eb = bq.size() ? bq.pop_front() : 2'h1;
      `CHK("bresp", eb, bresp)
    end
    if (active && !act_seen) begin
      ec = cq.size() ? cq.pop_front() : '0;
      `CHK("cmd", ec, cmd)
      `CHK("stall", 1'b1, cpu_stall)
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic timed_out();
    n_mismatch++;
    $display("CHECK FAILED wait expected 0 seen 1");
    end_of_test();
  endtask
  // Bus write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 100);
    if (n >= 100) timed_out();
  endtask
  // Bus read; f holds the data-check flag and the response
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [2:0] f = 3'h4);
    rq.push_back({f, d});
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 100);
    if (n >= 100) timed_out();
  endtask
  // Operation each code and erase setting should launch
  function automatic fpec_kind_type kind_of(input logic [4:0] c);
    case (c)
      5'h1F: return FK_BULK;
      5'h1D: return FK_GEN;
      5'h1C: return FK_SEC;
      5'h03: return FK_WORD;
      5'h12: return FK_PAGE;
      5'h01: return FK_ROW;
      5'h00: return FK_CFG_PROG;
      5'h10: return FK_CFG_ERASE;
      default: return FK_NONE;
    endcase
  endfunction
  // Set up, unlock, start, then wait for the end and read control back
  task automatic go(input logic [15:0] c, input fpec_kind_type k, input logic ab = 1'b0);
    logic pend;
    pend = ab;
    wr(OFS_CTRL, {16'h0000, c});
    wr(OFS_KEY, 32'h0000_0055);
    wr(OFS_KEY, 32'h0000_00AA);
    if (k != FK_NONE) cq.push_back({k, k == FK_PAGE ? tgt & PAGE_MASK : k == FK_ROW ? tgt & ROW_MASK : tgt});
    wr(OFS_CTRL, {16'h0000, c | 16'h8000});
    repeat (2) @(posedge clock_in); // Two idle slots after the start write
    if (ab) abort <= 1'b1;
    else if (k != FK_NONE) wr(OFS_CTRL, 32'h0000_0000);
    n = 0;
    while ((active || pend) && n < 200) begin
      @(posedge clock_in);
      abort <= 1'b0;
      pend = 1'b0;
      n++;
    end
    if (n >= 200) timed_out();
    rd(OFS_CTRL, {16'h0000, c | (ab ? 16'h2000 : 16'h0000)});
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    rd(OFS_CTRL, 32'h0000_0000);
    rd(OFS_KEY, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000, 3'h2);
    wr(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFS_CTRL, 32'h0000_1FB0);
    rd(OFS_CTRL, 32'h0000_0000);
    $display("test reset done");
    wr(OFS_CTRL, 32'h0000_C001);
    rd(OFS_CTRL, 32'h0000_6001);
    wr(OFS_KEY, 32'h0000_0055);
    wr(OFS_KEY, 32'h0000_00AA);
    wr(OFS_CTRL, 32'h0000_8001);
    rd(OFS_CTRL, 32'h0000_2001);
    wr(OFS_CTRL, 32'h0000_4001);
    wr(OFS_KEY, 32'h0000_0055);
    wr(OFS_PAGE, 32'h0000_0000);
    wr(OFS_KEY, 32'h0000_00AA);
    wr(OFS_CTRL, 32'h0000_C001);
    rd(OFS_CTRL, 32'h0000_6001);
    sys_rst_in <= 1'b1;
    @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    rd(OFS_CTRL, 32'h0000_6001);
    $display("test faults done");
    wr(OFS_PAGE, 32'h0000_0003);
    for (int i = 0; i < 64; i++) begin
      bw[i] = 24'($random(seed));
      wr(OFS_LOW, {16'h6000 + 16'(2 * i), bw[i][15:0]});
      wr(OFS_HIGH, {16'h6000 + 16'(2 * i), 8'h00, bw[i][23:16]});
    end
    for (int i = 0; i < 64; i += 21) begin
      bidx <= 6'(i);
      @(posedge clock_in);
      @(posedge clock_in);
      `CHK("buffer", bw[i], bword)
    end
    tgt = 24'h03_607E;
    go(16'h4001, FK_ROW);
    wr(OFS_PAGE, 32'h0000_0001);
    wr(OFS_LOW, 32'h6ABC_0000);
    tgt = 24'h01_6ABC;
    rd(OFS_STAT, {8'h00, tgt});
    go(16'h4042, FK_PAGE);
    go(16'h4001, FK_ROW);
    $display("test row and page done");
    for (int i = 0; i < 32; i++) begin
      go({9'h080, 1'(i >> 4), 2'h0, 4'(i)}, kind_of(5'(i)));
    end
    $display("test code table done");
    go(16'h4003, FK_WORD, 1'b1);
    rd(OFS_CTRL, 32'h0000_6003);
    arst_n_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    rd(OFS_CTRL, 32'h0000_0000);
    $display("test abort and reset done");
    end_of_test();
  end
endmodule
